// ### src/cnt_update_map.svh
// Widths, number ranges, selector codes, reset values and counts for the counter update block
`ifndef CNT_UPDATE_MAP_SVH
`define CNT_UPDATE_MAP_SVH
`define CNT_NUM_CHANNELS 5
`define CNT_NUM_W 3
`define CNT_WORD_W 16
`define CNT_VALUE_W 32
`define CNT_FIRST_NUM 3'h1
`define CNT_LAST_NUM 3'h5
`define CNT_PAIR_A_NUM 3'h1
`define CNT_PAIR_B_NUM 3'h3
`define CNT_SEL_BOTH 2'h0
`define CNT_SEL_FIRST 2'h1
`define CNT_SEL_SECOND 2'h2
`define CNT_RESET_VALUE 32'h0000_0000
`define CNT_RESET_CMP 32'h0000_0000
`endif

// ### src/cnt_update_pkg.sv
// Types shared by the counter update block
package cnt_update_pkg;
  // Overwrite request: counter number, then low and high words of the new count
  typedef struct packed {
    logic [2:0] counter_num;
    logic [15:0] value_lo;
    logic [15:0] value_hi;
  } overwrite_req_t;
  // Comparison load request: counter number, selector, first and second values
  typedef struct packed {
    logic [2:0] counter_num;
    logic [1:0] selector;
    logic [15:0] first_lo;
    logic [15:0] first_hi;
    logic [15:0] second_lo;
    logic [15:0] second_hi;
  } compare_req_t;
  // Checker verdict for one request
  typedef enum logic [1:0] {
    verdict_idle = 2'b00,
    verdict_accept = 2'b01,
    verdict_reject = 2'b10
  } verdict_t;
endpackage

// ### src/counter_channel.sv
// One counter channel: running count, two comparison values, match detection
`timescale 1ns/1ps
`default_nettype none
`include "cnt_update_map.svh"
module counter_channel #(
  parameter int VALUE_W = `CNT_VALUE_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic count_enable,
  input wire logic load_value,
  input wire logic [VALUE_W-1:0] new_value,
  input wire logic load_first,
  input wire logic load_second,
  input wire logic [VALUE_W-1:0] first_value,
  input wire logic [VALUE_W-1:0] second_value,
  output logic [VALUE_W-1:0] count_r,
  output logic [VALUE_W-1:0] first_r,
  output logic [VALUE_W-1:0] second_r,
  output logic match_r
);
  // Equal comparison values silence the match event
  wire logic cmp_equal;
  // Value the count takes this cycle
  wire logic [VALUE_W-1:0] count_nxt;
  // Raw match against either comparison value
  wire logic hit;

  assign cmp_equal = (first_r == second_r);
  // Overwrite wins over counting, so a load lands even mid-count
  assign count_nxt = load_value ? new_value : (count_enable ? count_r + 1'b1 : count_r);
  assign hit = (count_r == first_r) || (count_r == second_r);

  // Running count
  always_ff @(posedge clock) begin
    if (reset) begin
      count_r <= `CNT_RESET_VALUE;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Comparison values, replaced without pausing the count
  always_ff @(posedge clock) begin
    if (reset) begin
      first_r <= `CNT_RESET_CMP;
      second_r <= `CNT_RESET_CMP;
    end else begin
      if (load_first) begin
        first_r <= first_value;
      end
      if (load_second) begin
        second_r <= second_value;
      end
    end
  end

  // Match event, one cycle per matching count
  always_ff @(posedge clock) begin
    if (reset) begin
      match_r <= 1'b0;
    end else begin
      match_r <= count_enable && hit && !cmp_equal;
    end
  end
endmodule // counter_channel
`default_nettype wire

// ### src/counter_update.sv
// Counter preset and comparison update path for a bank of counters
//
// Overview of operation
// - Counter number 1-5; two-phase only 1 or 3
// - Overwrite count is 32 bits, low then high
// - Bad counter number: error flag, no change
// - Unconfigured counter input: reject, set error flag
// - Paired partner channel 2 or 4 is rejected
// - Overwrite accepted while counting, takes effect immediately
// - Selector 0 both, 1 first, 2 second
// - Comparison values 32 bits, low then high
// - Any invalid field: error flag, nothing loaded
// - Equal comparison values raise no match
// - Comparison loads accepted mid-count, applied at once
// - Overwrite with zero clears the count
`timescale 1ns/1ps
`default_nettype none
`include "cnt_update_map.svh"
module counter_update #(
  parameter int CHANNELS = `CNT_NUM_CHANNELS,
  parameter int VALUE_W = `CNT_VALUE_W
) (
  input wire logic clock,
  input wire logic reset,
  // Per-channel configuration: input set up as a counter
  input wire logic [CHANNELS-1:0] counter_configured,
  // Channel 1 and channel 3 running two-phase
  input wire logic pair_a_two_phase,
  input wire logic pair_b_two_phase,
  // Per-channel count enable from the counting logic
  input wire logic [CHANNELS-1:0] count_enable,
  // Value overwrite request, one-cycle strobe with its block
  input wire logic overwrite_strobe,
  input wire cnt_update_pkg::overwrite_req_t overwrite_req,
  // Comparison load request, one-cycle strobe with its block
  input wire logic compare_value_load_request,
  input wire cnt_update_pkg::compare_req_t compare_req,
  // Software clears the sticky error flag
  input wire logic error_clear,
  // Sticky error flag and its per-request pulse
  output logic data_error_flag,
  output logic error_condition_bit,
  // Request finished, accepted or rejected
  output logic done_r,
  // Bank state
  output logic [CHANNELS*VALUE_W-1:0] count_values,
  output logic [CHANNELS*VALUE_W-1:0] first_values,
  output logic [CHANNELS*VALUE_W-1:0] second_values,
  output logic [CHANNELS-1:0] match_events
);
  // Sticky error flag
  logic error_r;
  logic error_nxt;
  // One-cycle rejection pulse
  logic reject_r;
  // Verdict of the request in this cycle
  cnt_update_pkg::verdict_t verdict;

  // Decoded overwrite fields
  wire logic [2:0] ow_num;
  wire logic [VALUE_W-1:0] ow_value;
  // Decoded comparison fields
  wire logic [2:0] cp_num;
  wire logic [1:0] cp_sel;
  wire logic [VALUE_W-1:0] cp_first;
  wire logic [VALUE_W-1:0] cp_second;

  assign ow_num = overwrite_req.counter_num;
  // Low word first, high word second
  assign ow_value = {overwrite_req.value_hi, overwrite_req.value_lo};
  assign cp_num = compare_req.counter_num;
  assign cp_sel = compare_req.selector;
  assign cp_first = {compare_req.first_hi, compare_req.first_lo};
  assign cp_second = {compare_req.second_hi, compare_req.second_lo};

  // Only one request is served per cycle; overwrite takes priority
  wire logic take_ow;
  wire logic take_cp;
  assign take_ow = overwrite_strobe;
  assign take_cp = compare_value_load_request && !overwrite_strobe;

  // Number chosen by whichever request is served
  wire logic [2:0] sel_num;
  assign sel_num = take_ow ? ow_num : cp_num;

  // Number in range
  wire logic num_in_range;
  assign num_in_range = (sel_num >= `CNT_FIRST_NUM) && (sel_num <= `CNT_LAST_NUM);

  // Partner channel of a two-phase pair cannot be addressed
  wire logic num_is_partner;
  assign num_is_partner = (pair_a_two_phase && sel_num == `CNT_PAIR_A_NUM + 3'h1) ||
                          (pair_b_two_phase && sel_num == `CNT_PAIR_B_NUM + 3'h1);

  // Target index in the bank, zero when the number is out of range
  wire logic [2:0] sel_idx;
  assign sel_idx = num_in_range ? sel_num - 3'h1 : 3'h0;

  // Counter input set up for counting
  wire logic num_configured;
  assign num_configured = num_in_range && counter_configured[sel_idx];

  // Selector code known
  wire logic sel_valid;
  assign sel_valid = (cp_sel == `CNT_SEL_BOTH) || (cp_sel == `CNT_SEL_FIRST) ||
                     (cp_sel == `CNT_SEL_SECOND);

  // Overall request validity
  wire logic req_ok;
  assign req_ok = num_in_range && num_configured && !num_is_partner &&
                  (take_ow || sel_valid);

  // Which loads fire; nothing fires for a rejected request
  wire logic do_ow;
  wire logic do_first;
  wire logic do_second;
  assign do_ow = take_ow && req_ok;
  assign do_first = take_cp && req_ok && (cp_sel != `CNT_SEL_SECOND);
  assign do_second = take_cp && req_ok && (cp_sel != `CNT_SEL_FIRST);

  // Verdict of this cycle
  always_comb begin
    if (!(take_ow || take_cp)) begin
      verdict = cnt_update_pkg::verdict_idle;
    end else if (req_ok) begin
      verdict = cnt_update_pkg::verdict_accept;
    end else begin
      verdict = cnt_update_pkg::verdict_reject;
    end
  end

  // Error flag: a new rejection wins over a clear in the same cycle
  always_comb begin
    error_nxt = error_r;
    if (error_clear) begin
      error_nxt = 1'b0;
    end
    if (verdict == cnt_update_pkg::verdict_reject) begin
      error_nxt = 1'b1;
    end
  end

  // Flag and pulse registers
  always_ff @(posedge clock) begin
    if (reset) begin
      error_r <= 1'b0;
      reject_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      error_r <= error_nxt;
      reject_r <= (verdict == cnt_update_pkg::verdict_reject);
      done_r <= (verdict != cnt_update_pkg::verdict_idle);
    end
  end

  assign data_error_flag = error_r;
  assign error_condition_bit = reject_r;

  // One channel per counter, each loaded only when it is the target
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
      // Target decode for this channel
      wire logic hit_me;
      assign hit_me = (sel_idx == 3'(gi));
      counter_channel #(
        .VALUE_W(VALUE_W)
      ) u_chan (
        .clock(clock),
        .reset(reset),
        .count_enable(count_enable[gi]),
        .load_value(do_ow && hit_me),
        .new_value(ow_value),
        .load_first(do_first && hit_me),
        .load_second(do_second && hit_me),
        .first_value(cp_first),
        .second_value(cp_second),
        .count_r(count_values[gi*VALUE_W +: VALUE_W]),
        .first_r(first_values[gi*VALUE_W +: VALUE_W]),
        .second_r(second_values[gi*VALUE_W +: VALUE_W]),
        .match_r(match_events[gi])
      );
    end
  endgenerate
endmodule // counter_update
`default_nettype wire

// ### testbench/counter_update_assertions.sv
// Assertion checker for the counter update block
`timescale 1ns/1ps
`default_nettype none
module counter_update_checker #(
  parameter int CHANNELS = 5,
  parameter int VALUE_W = 32
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [CHANNELS-1:0] counter_configured,
  input wire logic pair_a_two_phase,
  input wire logic pair_b_two_phase,
  input wire logic [CHANNELS-1:0] count_enable,
  input wire logic overwrite_strobe,
  input wire cnt_update_pkg::overwrite_req_t overwrite_req,
  input wire logic compare_value_load_request,
  input wire cnt_update_pkg::compare_req_t compare_req,
  input wire logic data_error_flag,
  input wire logic error_condition_bit,
  input wire logic done_r,
  input wire logic [CHANNELS*VALUE_W-1:0] count_values,
  input wire logic [CHANNELS*VALUE_W-1:0] first_values,
  input wire logic [CHANNELS*VALUE_W-1:0] second_values,
  input wire logic [CHANNELS-1:0] match_events
);
  // Shorthands for request fields
  wire logic [2:0] onum = overwrite_req.counter_num;
  wire logic req = overwrite_strobe | compare_value_load_request;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_req_done: assert property (req |=> done_r) else $error("request not served");
  a_done_cause: assert property (done_r |-> $past(req)) else $error("stray done");
  a_err_flag: assert property (error_condition_bit |-> data_error_flag && done_r) else $error("flag missing");
  a_bad_num: assert property (overwrite_strobe && !(onum inside {[1:5]}) |=> error_condition_bit)
    else $error("bad number taken");
  a_unconf_rej: assert property (overwrite_strobe && onum inside {[1:5]} && !counter_configured[onum-3'h1]
    |=> error_condition_bit) else $error("unconfigured taken");
  a_pair_rej: assert property (overwrite_strobe && ((onum == 3'h2 && pair_a_two_phase)
    || (onum == 3'h4 && pair_b_two_phase)) |=> error_condition_bit) else $error("pair taken");
  a_sel_rej: assert property (compare_value_load_request && !overwrite_strobe && compare_req.selector == 2'h3
    |=> error_condition_bit) else $error("bad selector taken");
  a_reject_hold: assert property (error_condition_bit |-> $stable(first_values) && $stable(second_values))
    else $error("reject changed state");
  a_equal_quiet: assert property (match_events[0] |-> $past(first_values[31:0]) != $past(second_values[31:0]))
    else $error("match on equal values");
  a_match_hit: assert property (count_enable[0] && count_values[31:0] == first_values[31:0]
    && first_values[31:0] != second_values[31:0] |=> match_events[0]) else $error("match missed");
  c_reject: cover property (error_condition_bit);
  c_match: cover property (match_events[0]);
  c_busy_write: cover property (overwrite_strobe && count_enable != 5'h00);
endmodule // counter_update_checker
bind counter_update counter_update_checker #(.CHANNELS(CHANNELS), .VALUE_W(VALUE_W)) i_chk (.*);
`default_nettype wire

// ### testbench/update_requester.sv
// Model of the controller program issuing update requests
`timescale 1ns/1ps
`default_nettype none
module update_requester (
  input wire logic clock,
  output logic ovs,
  output cnt_update_pkg::overwrite_req_t ovr,
  output logic cls,
  output cnt_update_pkg::compare_req_t clr
);
  // Idle at time zero
  initial begin
    ovs = 1'b0;
    cls = 1'b0;
    ovr = '0;
    clr = '0;
  end
  // Whole three-word block per strobe, payload scrambled after release
  task automatic put_count(input logic [2:0] n, input logic [31:0] v);
    @(posedge clock);
    #2;
    ovs = 1'b1;
    ovr = '{n, v[15:0], v[31:16]};
    @(posedge clock);
    #2;
    ovs = 1'b0;
    ovr = ~ovr;
  endtask
  // Whole six-word block per strobe
  task automatic put_cmp(input logic [2:0] n, input logic [1:0] s, input logic [31:0] a, input logic [31:0] b);
    @(posedge clock);
    #2;
    cls = 1'b1;
    clr = '{n, s, a[15:0], a[31:16], b[15:0], b[31:16]};
    @(posedge clock);
    #2;
    cls = 1'b0;
    clr = ~clr;
  endtask
endmodule // update_requester
`default_nettype wire

// ### testbench/counter_update_test.sv
// Self-checking bench for the counter update block
`timescale 1ns/1ps
`default_nettype none
module counter_update_test;
  logic clock, reset, pa, pb, ec, def, ecb, done, ovs, cls, a;
  logic [4:0] cfg, en, mev;
  logic [159:0] cv, fv, sv;
  logic [31:0] lf, v, w, ef [5], es [5];
  logic [2:0] n;
  logic [1:0] s;
  cnt_update_pkg::overwrite_req_t ovr;
  cnt_update_pkg::compare_req_t clr;
  int mismatches = 0, n_compared = 0, cyc = 0;
  update_requester i_req (.clock(clock), .ovs(ovs), .ovr(ovr), .cls(cls), .clr(clr));
  counter_update i_dut (.clock(clock), .reset(reset), .counter_configured(cfg), .pair_a_two_phase(pa),
    .pair_b_two_phase(pb), .count_enable(en), .overwrite_strobe(ovs), .overwrite_req(ovr),
    .compare_value_load_request(cls), .compare_req(clr), .error_clear(ec), .data_error_flag(def),
    .error_condition_bit(ecb), .done_r(done), .count_values(cv), .first_values(fv),
    .second_values(sv), .match_events(mev));
  // Pseudo-random source
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected acceptance of a counter number
  function automatic logic acc(input logic [2:0] k);
    return k inside {[1:5]} && cfg[k-3'h1] && !(k == 3'h2 && pa) && !(k == 3'h4 && pb);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    {reset, cfg, pa, pb, en, ec} = {1'b1, 13'h0};
    lf = 32'h20818609;
    foreach (ef[i]) {ef[i], es[i]} = 64'h0;
    repeat (10) @(posedge clock);
    #2;
    reset = 1'b0;
    // Random requests; first eight walk every number with extreme values
    for (int k = 0; k < 300; k++) begin
      lf = nx(lf);
      {pb, pa, en, cfg, ec} = {lf[12:0] | {7'h0, lf[17:13], 1'b0}};
      n = k < 8 ? k[2:0] : lf[20:18];
      s = lf[22:21];
      v = k < 8 ? {32{k[0]}} : nx(lf);
      w = nx(v);
      if (lf[23]) begin
        a = acc(n);
        i_req.put_count(n, v);
        if (a) chk(cv[32*(n-3'h1)+:32], v);
      end else begin
        a = acc(n) && s != 2'h3;
        i_req.put_cmp(n, s, v, w);
        if (a && s != 2'h2) ef[n-3'h1] = v;
        if (a && s != 2'h1) es[n-3'h1] = w;
        for (int i = 0; i < 5; i++) chk(fv[32*i+:32] ^ sv[32*i+:32], ef[i] ^ es[i]);
        for (int i = 0; i < 5; i++) chk(fv[32*i+:32], ef[i]);
        for (int i = 0; i < 5; i++) chk(sv[32*i+:32], es[i]);
      end
      chk(32'({done, ecb}), 32'({1'b1, !a}));
      if (!a) chk(32'(def), 32'h1);
    end
    $display("random test done");
    {en, cfg, pa, pb, ec} = {5'h0, 5'h1f, 3'h0};
    // Distinct then equal comparison values
    for (int j = 0; j < 2; j++) begin
      i_req.put_cmp(3'h1, 2'h0, 32'h5, j ? 32'h5 : 32'h9);
      i_req.put_count(3'h1, 32'h5);
      en = 5'h01;
      @(posedge clock);
      #2;
      en = 5'h00;
      chk(32'(mev[0]), 32'(j == 0));
    end
    ec = 1'b1;
    @(posedge clock);
    #2;
    ec = 1'b0;
    chk(32'(def), 32'h0);
    $display("match test done");
    summarize();
  end
endmodule // counter_update_test
`default_nettype wire
